// [design/rivl_defs.svh]
// Purpose: Constants for the reset and interrupt vector locator.
// Assumes: Word addresses into program flash, 16 bits wide (64K words).
// Notes: Boot section starts are selected by the two-bit boot-size fuse.
`ifndef RIVL_DEFS_SVH
`define RIVL_DEFS_SVH

`define RIVL_ADDR_W 16
`define RIVL_NUM_SRC 34
`define RIVL_SRC_W 6
`define RIVL_RESET_ADDR 16'h0000
`define RIVL_FIRST_IRQ_OFS 16'h0002
`define RIVL_LAST_IRQ_OFS 16'h0044
`define RIVL_VEC_STEP 16'h0002
`define RIVL_FUSE_PROGRAMMED 1'h0
`define RIVL_SEL_RESET 1'h0
`define RIVL_BOOT_START_0 16'hf000
`define RIVL_BOOT_START_1 16'hf800
`define RIVL_BOOT_START_2 16'hfc00
`define RIVL_BOOT_START_3 16'hfe00

`endif

// [design/rivl_pkg.sv]
// Purpose: Types shared by the vector locator.
// Assumes: Constants come from rivl_defs.svh.
// Notes: None.
`include "rivl_defs.svh"
package rivl_pkg;
    typedef enum logic [0:0] {
        RIVL_IDLE = 1'b0,
        RIVL_HOLD = 1'b1
    } rivl_state_t;

    typedef struct packed {
        logic valid;
        logic [`RIVL_SRC_W-1:0] number;
        logic [`RIVL_ADDR_W-1:0] addr;
    } rivl_vec_t;
endpackage : rivl_pkg

// [design/rivl_vector_locator.sv]
// Purpose: Forms reset and interrupt vector word addresses for the core.
// Assumes: Fuses and the select bit are steady levels synchronous to ref_clk.
// Notes: Request bit 0 is vector number 2; bit 33 is vector number 35.
`timescale 1ns/10ps
`default_nettype none
`include "rivl_defs.svh"

// Notes on behaviour
// R1 - Unprogrammed boot-reset fuse: every reset starts execution at address zero.
// R2 - External requests zero to two sit at offsets 2, 4 and 6.
// R3 - Pin-change groups zero to three sit at offsets 8 through E.
// R4 - Watchdog at 10; timer 2 match A, match B, overflow at 12 to 16.
// R5 - Timer 1 capture, match A, match B, overflow at 18 to 1E.
// R6 - Timer 0 match A, match B, overflow at 20 to 24.
// R7 - Serial peripheral at 26; port 0 receive, empty, transmit at 28 to 2C.
// R8 - Comparator 2E, converter 30, data ready 32, two-wire 34, store ready 36.
// R9 - Port 1 receive, empty, transmit at 38 to 3C.
// R10 - Timer 3 capture to overflow at 3E to 44; 35 vectors total.
// R11 - Programmed boot-reset fuse moves the reset vector to the boot start.
// R12 - Select bit set adds the boot start to every interrupt offset.
// R13 - Table start depends on select bit only, never on the fuse.
// R14 - Fuse value one means unprogrammed, zero means programmed.
// R15 - Boot start address comes from the boot-size fuse.
// R16 - The select bit resets to zero.
// R17 - Lowest-numbered pending source wins; addresses follow fuses combinationally.
module rivl_vector_locator (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic boot_reset_fuse,
    input wire logic [1:0] boot_size_fuse,
    input wire logic selWrEn,
    input wire logic selWrData,
    input wire logic [`RIVL_NUM_SRC-1:0] irqReq,
    input wire logic irqAck,
    output logic [`RIVL_ADDR_W-1:0] resetAddr,
    output logic [`RIVL_ADDR_W-1:0] tableStart,
    output logic vector_table_select,
    output logic irqPending,
    output logic [`RIVL_ADDR_W-1:0] pendAddr,
    output var rivl_pkg::rivl_vec_t ackVec_q
);
    logic selQ_q;
    logic selQ_d;
    logic [`RIVL_ADDR_W-1:0] bootStart;
    logic [`RIVL_ADDR_W-1:0] irqBase;
    logic [`RIVL_ADDR_W-1:0] ofsTab [`RIVL_NUM_SRC];
    logic [`RIVL_SRC_W-1:0] winIdx;
    rivl_pkg::rivl_vec_t ackVec_d;

    // R15 boot start decode
    always_comb begin
        unique case (boot_size_fuse)
            2'h0: bootStart = `RIVL_BOOT_START_0;
            2'h1: bootStart = `RIVL_BOOT_START_1;
            2'h2: bootStart = `RIVL_BOOT_START_2;
            2'h3: bootStart = `RIVL_BOOT_START_3;
        endcase
    end

    // R1 R11 R14 reset placement
    assign resetAddr = (boot_reset_fuse == `RIVL_FUSE_PROGRAMMED) ? bootStart : `RIVL_RESET_ADDR;

    // R12 R13 table base from select only
    assign irqBase = selQ_q ? bootStart : 16'h0000;
    assign tableStart = irqBase + `RIVL_FIRST_IRQ_OFS;
    assign vector_table_select = selQ_q;

    // The guarded write sequence lives with the core; here the write is taken as already qualified.
    always_comb begin
        selQ_d = selQ_q;
        if (selWrEn) begin
            selQ_d = selWrData;
        end
    end

    // R16 select resets clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            selQ_q <= `RIVL_SEL_RESET;
        end else begin
            selQ_q <= selQ_d;
        end
    end

    // Each vector holds a two-word jump, so offsets grow by one fixed step per source index.
    // R2 R3 R4 R5 R6 R7 R8 R9 R10 offset table, one word pair per source
    for (genvar i = 0; i < `RIVL_NUM_SRC; i++) begin : g_ofs
        assign ofsTab[i] = `RIVL_FIRST_IRQ_OFS + 16'(`RIVL_VEC_STEP * i);
    end

    // R17 lowest source wins
    always_comb begin
        winIdx = '0;
        irqPending = 1'b0;
        // Scanning from the top down lets the lowest set bit overwrite any higher one.
        for (int k = `RIVL_NUM_SRC - 1; k >= 0; k--) begin
            if (irqReq[k]) begin
                winIdx = 6'(k);
                irqPending = 1'b1;
            end
        end
    end

    assign pendAddr = irqBase + ofsTab[winIdx];

    // Acknowledge captures the address so the core sees a steady value while fetching.
    always_comb begin
        ackVec_d = ackVec_q;
        // Valid is a one-cycle pulse; number and address hold so the core may read them late.
        ackVec_d.valid = 1'b0;
        if (irqAck && irqPending) begin
            ackVec_d.valid = 1'b1;
            ackVec_d.number = 6'(winIdx + 6'h2);
            ackVec_d.addr = pendAddr;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ackVec_q <= '0;
        end else begin
            ackVec_q <= ackVec_d;
        end
    end

    // Offsets are checked with the select bit clear, so that a wrong table entry cannot hide
    // behind a wrong base; relocation is checked on its own.
    // R1 reset at zero
    a_reset_at_zero: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
        boot_reset_fuse |-> resetAddr == 16'h0000) else $error("reset vector not at zero");

    // R11 reset at boot
    a_reset_at_boot: assert property (@(posedge ref_clk) disable iff (!rst_b) // R11
        !boot_reset_fuse |-> resetAddr == bootStart) else $error("reset vector not at boot start");

    // R13 table start placement
    a_table_start: assert property (@(posedge ref_clk) disable iff (!rst_b) // R13
        tableStart == (selQ_q ? bootStart + 16'h0002 : 16'h0002)) else $error("table start wrong");

    // R13 reset ignores select
    a_reset_no_select: assert property (@(posedge ref_clk) disable iff (!rst_b) // R13
        ($changed(selQ_q) && $stable(boot_reset_fuse) && $stable(boot_size_fuse))
        |-> $stable(resetAddr))
        else $error("reset vector moved with the select bit");

    // R16 select resets clear
    a_select_reset: assert property (@(posedge ref_clk) // R16
        !rst_b |=> !vector_table_select && ackVec_q == 23'h000000)
        else $error("select bit or vector not cleared by reset");

    // R16 select bit write
    a_select_write: assert property (@(posedge ref_clk) disable iff (!rst_b) // R16
        selWrEn |=> vector_table_select == $past(selWrData)) else $error("select bit not written");

    // R2 first external request
    a_ext_zero_ofs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
        (irqReq[0] && !selQ_q) |-> pendAddr == 16'h0002) else $error("first vector wrong");

    // R2 third external request
    a_ext_two_ofs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
        (irqReq[2] && irqReq[1:0] == 2'h0 && !selQ_q) |-> pendAddr == 16'h0006)
        else $error("third external vector wrong");

    // R3 first pin group
    a_pin_first_ofs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
        (irqReq[3] && irqReq[2:0] == 3'h0 && !selQ_q) |-> pendAddr == 16'h0008)
        else $error("first pin-change vector wrong");

    // R3 last pin group
    a_pin_last_ofs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
        (irqReq[6] && irqReq[5:0] == 6'h00 && !selQ_q) |-> pendAddr == 16'h000e)
        else $error("last pin-change vector wrong");

    // R4 watchdog vector offset
    a_watchdog_ofs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R4
        (irqReq[7] && irqReq[6:0] == 7'h00 && !selQ_q) |-> pendAddr == 16'h0010)
        else $error("watchdog vector wrong");

    // R5 timer 1 overflow
    a_t1_last_ofs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
        (irqReq[14] && irqReq[13:0] == 14'h0000 && !selQ_q) |-> pendAddr == 16'h001e)
        else $error("timer 1 overflow vector wrong");

    // R6 timer 0 overflow
    a_t0_last_ofs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
        (irqReq[17] && irqReq[16:0] == 17'h00000 && !selQ_q) |-> pendAddr == 16'h0024)
        else $error("timer 0 overflow vector wrong");

    // R7 serial peripheral done
    a_serial_ofs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
        (irqReq[18] && irqReq[17:0] == 18'h00000 && !selQ_q) |-> pendAddr == 16'h0026)
        else $error("serial peripheral vector wrong");

    // R8 store ready vector
    a_store_ready_ofs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R8
        (irqReq[26] && irqReq[25:0] == 26'h0000000 && !selQ_q) |-> pendAddr == 16'h0036)
        else $error("store ready vector wrong");

    // R9 port 1 transmit
    a_port1_last_ofs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R9
        (irqReq[29] && irqReq[28:0] == 29'h00000000 && !selQ_q) |-> pendAddr == 16'h003c)
        else $error("port 1 transmit vector wrong");

    // R10 last vector offset
    a_last_vec_ofs: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
        (irqReq == 34'h200000000 && !selQ_q) |-> pendAddr == 16'h0044) else $error("last vector wrong");

    // R12 boot relocation
    a_boot_relocate: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
        (irqReq == 34'h000000100 && selQ_q) |-> pendAddr == bootStart + 16'h0012) else $error("relocation wrong");

    // R17 pending follows requests
    a_pend_any: assert property (@(posedge ref_clk) disable iff (!rst_b) // R17
        irqPending == (irqReq != 34'h000000000))
        else $error("pending flag does not follow requests");

    // R17 lowest source wins
    a_lowest_wins: assert property (@(posedge ref_clk) disable iff (!rst_b) // R17
        irqPending |-> irqReq[winIdx] && ((irqReq & ((34'h000000001 << winIdx) - 34'h000000001)) == 34'h000000000))
        else $error("pending source is not the lowest");

    // R17 acknowledge capture
    a_ack_capture: assert property (@(posedge ref_clk) disable iff (!rst_b) // R17
        (irqAck && irqPending) |=> ackVec_q.valid && ackVec_q.addr == $past(pendAddr))
        else $error("acknowledge not captured");

    // R17 acknowledge number pairing
    a_ack_number: assert property (@(posedge ref_clk) disable iff (!rst_b) // R17
        (irqAck && irqPending) |=> ackVec_q.number == $past(winIdx) + 6'h02)
        else $error("acknowledge number wrong");

    // R17 refused acknowledge
    a_ack_refused: assert property (@(posedge ref_clk) disable iff (!rst_b) // R17
        !(irqAck && irqPending) |=> !ackVec_q.valid && $stable(ackVec_q.number) && $stable(ackVec_q.addr))
        else $error("acknowledge without request changed the vector");
endmodule : rivl_vector_locator
`default_nettype wire

// [tb/rivl_core_model.sv]
// Purpose: Core side that answers the bench with an acknowledge.
// Assumes: One acknowledge pulse per command pulse.
// Notes: A command with nothing pending still acknowledges.
`timescale 1ns/10ps
`default_nettype none
module rivl_core_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ackGo,
    output logic irqAck
);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqAck <= 1'h0;
        end else begin
            irqAck <= ackGo;
        end
    end
endmodule : rivl_core_model
`default_nettype wire

// [tb/reset_irq_vector_locator_tb.sv]
// Purpose: Self-checking bench for the vector locator.
// Assumes: The core model acknowledges one cycle after its command.
// Notes: Expected addresses are built from the offset step.
`timescale 1ns/10ps
`default_nettype none
`include "rivl_defs.svh"
module reset_irq_vector_locator_tb;
    logic ref_clk = 1'h0, rst_b = 1'h0, boot_reset_fuse = 1'h1, selWrEn = 1'h0, selWrData = 1'h0;
    logic ackGo = 1'h0, irqAck, irqPending, vector_table_select;
    logic [1:0] boot_size_fuse = 2'h0;
    logic [33:0] irqReq = 34'h0;
    logic [15:0] resetAddr, tableStart, pendAddr;
    rivl_pkg::rivl_vec_t ackVec_q;
    int n_fail = 0;
    int n_compared = 0;
    always #2.5 ref_clk = ~ref_clk;
    rivl_vector_locator i_rivl_vector_locator (.ref_clk, .rst_b, .boot_reset_fuse, .boot_size_fuse,
        .selWrEn, .selWrData, .irqReq, .irqAck, .resetAddr, .tableStart, .vector_table_select,
        .irqPending, .pendAddr, .ackVec_q);
    rivl_core_model i_rivl_core_model (.ref_clk, .rst_b, .ackGo, .irqAck);
    function automatic logic [15:0] bootAt(input logic [1:0] s);
        return s[1] ? (s[0] ? `RIVL_BOOT_START_3 : `RIVL_BOOT_START_2)
                    : (s[0] ? `RIVL_BOOT_START_1 : `RIVL_BOOT_START_0);
    endfunction : bootAt
    task automatic check(input logic [22:0] seen, input logic [22:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic t_fuses();
        for (int s = 0; s < 8; s++) begin
            @(posedge ref_clk);
            boot_size_fuse <= s[1:0];
            boot_reset_fuse <= s[2];
            @(negedge ref_clk);
            check(resetAddr, s[2] ? `RIVL_RESET_ADDR : bootAt(s[1:0]));
            check(tableStart, `RIVL_FIRST_IRQ_OFS);
            check(vector_table_select, `RIVL_SEL_RESET);
        end
    endtask : t_fuses
    task automatic t_table(input logic sel, input logic fuse);
        logic [15:0] base;
        @(posedge ref_clk);
        selWrEn <= 1'h1;
        selWrData <= sel;
        boot_reset_fuse <= fuse;
        @(posedge ref_clk);
        selWrEn <= 1'h0;
        base = sel ? bootAt(boot_size_fuse) : 16'h0000;
        for (int i = 0; i < 34; i++) begin
            irqReq <= 34'h1 << i;
            @(negedge ref_clk);
            check(pendAddr, base + `RIVL_FIRST_IRQ_OFS + `RIVL_VEC_STEP * i[15:0]);
            check(tableStart, base + `RIVL_FIRST_IRQ_OFS);
            check(resetAddr, fuse ? `RIVL_RESET_ADDR : bootAt(boot_size_fuse));
            @(posedge ref_clk);
        end
    endtask : t_table
    task automatic t_ack();
        logic [15:0] ofs;
        ofs = bootAt(boot_size_fuse) + 16'h000c;
        irqReq <= 34'h100020;
        ackGo <= 1'h1;
        @(posedge ref_clk);
        ackGo <= 1'h0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check(ackVec_q, {1'h1, 6'h07, ofs});
        @(posedge ref_clk);
        irqReq <= 34'h0;
        ackGo <= 1'h1;
        @(posedge ref_clk);
        ackGo <= 1'h0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check(irqPending, 1'h0);
        check(ackVec_q, {1'h0, 6'h07, ofs});
    endtask : t_ack
    task automatic t_rerst();
        @(posedge ref_clk);
        rst_b <= 1'h0;
        boot_size_fuse <= 2'h0;
        irqReq <= 34'h1;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'h1;
        @(negedge ref_clk);
        check(vector_table_select, `RIVL_SEL_RESET);
        check(ackVec_q, 23'h000000);
        check(pendAddr, `RIVL_FIRST_IRQ_OFS);
        check(resetAddr, `RIVL_BOOT_START_0);
        @(posedge ref_clk);
        selWrEn <= 1'h1;
        selWrData <= 1'h1;
        @(posedge ref_clk);
        selWrEn <= 1'h0;
        @(negedge ref_clk);
        check(pendAddr, `RIVL_BOOT_START_0 + `RIVL_FIRST_IRQ_OFS);
        check(tableStart, `RIVL_BOOT_START_0 + `RIVL_FIRST_IRQ_OFS);
    endtask : t_rerst
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'h1;
        t_fuses();
        t_table(1'h0, 1'h1);
        t_table(1'h1, 1'h0);
        t_ack();
        t_rerst();
        give_verdict();
    end
endmodule : reset_irq_vector_locator_tb
`default_nettype wire
